// File: design/pcs_stat_counters.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps
`include "pcs_consts.svh"
//
// Contract
// - Count received good-CRC frames of 64 to 1518 bytes, 32 bits, low half own register.
// - Count received good-CRC frames over 1518 bytes, 32 bits, high and low registers.
// - Count received good-CRC frames under 64 bytes, 32 bits, high and low registers.
// - Count received bad-CRC frames of 64 to 1518 bytes, 16 bits.
// - Count received bad-CRC frames over 1518 bytes, 16 bits.
// - Count received fragments under 64 bytes whatever the CRC, 16 bits.
// - Count received frames with no start-of-frame delimiter, 16 bits.
// - Count transmitted good-CRC frames of 64 to 1518 bytes, 32 bits, two registers.
// - Count transmitted good-CRC frames over 1518 bytes, 32 bits, two registers.
// - Count transmitted good-CRC frames under 64 bytes, 32 bits, two registers.
// - Count transmitted bad-CRC frames of 64 to 1518 bytes, 16 bits.
// - Count transmitted bad-CRC frames over 1518 bytes, 16 bits.
// - Count transmit-side fragments under 64 bytes, 16 bits.
// - Count transmit-side frames missing the start-of-frame delimiter, 16 bits.
// - Counters are read-only, reset to zero, and clear on read.
// - High half of the receive good counter sits just before its low half.
// - Checkers examine and count frames only while checker enable is set.
// - Transmit source select picks generator frames when 1, MAC frames when 0.
module pcs_stat_counters (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire pcs_pkg::pcs_word_t reg_addr,
	input wire pcs_pkg::pcs_word_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output pcs_pkg::pcs_word_t reg_rdata,
	// Receive nibble stream from the wire side
	input wire logic rx_nib_vld,
	input wire logic rx_dv,
	input wire pcs_pkg::pcs_nib_t rx_nib,
	// Transmit nibble stream from the MAC
	input wire logic mac_tx_nib_vld,
	input wire logic mac_tx_en,
	input wire pcs_pkg::pcs_nib_t mac_tx_nib,
	// Transmit nibble stream from the packet generator
	input wire logic gen_tx_nib_vld,
	input wire logic gen_tx_en,
	input wire pcs_pkg::pcs_nib_t gen_tx_nib,
	// Interrupt
	output logic irq
);
	import pcs_pkg::*;

	localparam int NCNT = 14;
	localparam int NDIR = 7;
	localparam int NWIDE = 3;

	// Control registers
	logic checker_enable_reg;
	logic tx_checker_source_select_reg;
	logic [NCNT-1:0] irq_stat_reg, irq_stat_next;
	logic [NCNT-1:0] irq_mask_reg;
	pcs_word_t rdata_reg, rdata_next;

	// Counter bank with shadow of the low half for wide counters
	logic [31:0] cnt_reg [NCNT];
	logic [31:0] cnt_next [NCNT];
	logic [15:0] shadow_reg [NCNT];
	logic [NCNT-1:0] shv_reg;

	// Per-counter views for the read path
	logic [15:0] hi_view [NCNT];
	logic [15:0] lo_view [NCNT];
	logic [NCNT-1:0] rd_hi;
	logic [NCNT-1:0] rd_lo;
	logic [NCNT-1:0] ev_all;

	pcs_evt_if rx_ev ();
	pcs_evt_if tx_ev ();

	// Transmit checker input selection
	wire tx_sel_vld = tx_checker_source_select_reg ? gen_tx_nib_vld : mac_tx_nib_vld;
	wire tx_sel_dv = tx_checker_source_select_reg ? gen_tx_en : mac_tx_en;
	wire [3:0] tx_sel_nib = tx_checker_source_select_reg ? gen_tx_nib : mac_tx_nib;

	// Receive side checker
	pcs_frame_check u_rx_chk (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.enable(checker_enable_reg),
		.nib_vld(rx_nib_vld),
		.frame_dv(rx_dv),
		.nib(rx_nib),
		.ev(rx_ev.src)
	);

	// Transmit side checker
	pcs_frame_check u_tx_chk (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.enable(checker_enable_reg),
		.nib_vld(tx_sel_vld),
		.frame_dv(tx_sel_dv),
		.nib(tx_sel_nib),
		.ev(tx_ev.src)
	);

	assign ev_all = {tx_ev.evt, rx_ev.evt};

	// Address decode for the status read strobe and the control and mask write strobes
	wire rd_stat = reg_rd && (reg_addr == `PCS_ADDR_IRQ_STAT);
	wire wr_ctrl = reg_wr && (reg_addr == `PCS_ADDR_CTRL);
	wire wr_ctrl2 = reg_wr && (reg_addr == `PCS_ADDR_CTRL2);
	wire wr_mask = reg_wr && (reg_addr == `PCS_ADDR_IRQ_MASK);

	// High-half reads of the wide counters
	assign rd_hi[0] = reg_rd && (reg_addr == `PCS_ADDR_RX_GOOD_HI);
	assign rd_hi[1] = reg_rd && (reg_addr == `PCS_ADDR_RX_OVER_HI);
	assign rd_hi[2] = reg_rd && (reg_addr == `PCS_ADDR_RX_UNDER_HI);
	assign rd_hi[3] = 1'b0;
	assign rd_hi[4] = 1'b0;
	assign rd_hi[5] = 1'b0;
	assign rd_hi[6] = 1'b0;
	assign rd_hi[7] = reg_rd && (reg_addr == `PCS_ADDR_TX_GOOD_HI);
	assign rd_hi[8] = reg_rd && (reg_addr == `PCS_ADDR_TX_OVER_HI);
	assign rd_hi[9] = reg_rd && (reg_addr == `PCS_ADDR_TX_UNDER_HI);
	assign rd_hi[10] = 1'b0;
	assign rd_hi[11] = 1'b0;
	assign rd_hi[12] = 1'b0;
	assign rd_hi[13] = 1'b0;

	// Low-half reads, and single reads of the narrow counters
	assign rd_lo[0] = reg_rd && (reg_addr == `PCS_ADDR_RX_GOOD_LO);
	assign rd_lo[1] = reg_rd && (reg_addr == `PCS_ADDR_RX_OVER_LO);
	assign rd_lo[2] = reg_rd && (reg_addr == `PCS_ADDR_RX_UNDER_LO);
	assign rd_lo[3] = reg_rd && (reg_addr == `PCS_ADDR_RX_INERR);
	assign rd_lo[4] = reg_rd && (reg_addr == `PCS_ADDR_RX_OVERERR);
	assign rd_lo[5] = reg_rd && (reg_addr == `PCS_ADDR_RX_FRAG);
	assign rd_lo[6] = reg_rd && (reg_addr == `PCS_ADDR_RX_NOSFD);
	assign rd_lo[7] = reg_rd && (reg_addr == `PCS_ADDR_TX_GOOD_LO);
	assign rd_lo[8] = reg_rd && (reg_addr == `PCS_ADDR_TX_OVER_LO);
	assign rd_lo[9] = reg_rd && (reg_addr == `PCS_ADDR_TX_UNDER_LO);
	assign rd_lo[10] = reg_rd && (reg_addr == `PCS_ADDR_TX_INERR);
	assign rd_lo[11] = reg_rd && (reg_addr == `PCS_ADDR_TX_OVERERR);
	assign rd_lo[12] = reg_rd && (reg_addr == `PCS_ADDR_TX_FRAG);
	assign rd_lo[13] = reg_rd && (reg_addr == `PCS_ADDR_TX_NOSFD);

	// One counter per generate entry
	for (genvar i = 0; i < NCNT; i++) begin : g_cnt
		localparam bit WIDE = (i % NDIR) < NWIDE;
		localparam logic [31:0] CMAX = WIDE ? 32'hFFFF_FFFF : 32'h0000_FFFF;
		wire inc = ev_all[i];
		wire at_max = (cnt_reg[i] == CMAX);
		wire [31:0] plus = at_max ? cnt_reg[i] : cnt_reg[i] + 32'h0000_0001;
		wire [31:0] lo_cleared = {cnt_reg[i][31:16], 15'h0000, inc};

		// Next count: a read clears, except a low-half read while the shadow is valid; an increment in the same cycle survives
		always_comb begin
			if (rd_hi[i]) begin
				cnt_next[i] = {31'h0000_0000, inc};
			end else if (rd_lo[i] && !(WIDE && shv_reg[i])) begin
				cnt_next[i] = WIDE ? lo_cleared : {31'h0000_0000, inc};
			end else if (inc) begin
				cnt_next[i] = plus;
			end else begin
				cnt_next[i] = cnt_reg[i];
			end
		end

		// Counter and low-half shadow registers
		always_ff @(posedge core_clk or negedge rst_n) begin
			if (!rst_n) begin
				cnt_reg[i] <= `PCS_RST_CNT;
				shadow_reg[i] <= `PCS_RST_WORD;
				shv_reg[i] <= 1'b0;
			end else begin
				cnt_reg[i] <= cnt_next[i];
				if (rd_hi[i]) begin
					shadow_reg[i] <= cnt_reg[i][15:0];
					shv_reg[i] <= 1'b1;
				end else if (rd_lo[i]) begin
					shv_reg[i] <= 1'b0;
				end
			end
		end

		assign hi_view[i] = cnt_reg[i][31:16];
		assign lo_view[i] = (WIDE && shv_reg[i]) ? shadow_reg[i] : cnt_reg[i][15:0];
	end

	// Read data multiplexer; unmapped offsets read as zero
	always_comb begin
		rdata_next = `PCS_RST_WORD;
		if (reg_rd) begin
			case (reg_addr)
				`PCS_ADDR_CTRL: rdata_next[`PCS_BIT_CHK_EN] = checker_enable_reg;
				`PCS_ADDR_CTRL2: rdata_next[`PCS_BIT_TX_SRC] = tx_checker_source_select_reg;
				`PCS_ADDR_IRQ_STAT: rdata_next = {2'h0, irq_stat_reg};
				`PCS_ADDR_IRQ_MASK: rdata_next = {2'h0, irq_mask_reg};
				`PCS_ADDR_RX_GOOD_HI: rdata_next = hi_view[0];
				`PCS_ADDR_RX_GOOD_LO: rdata_next = lo_view[0];
				`PCS_ADDR_RX_OVER_HI: rdata_next = hi_view[1];
				`PCS_ADDR_RX_OVER_LO: rdata_next = lo_view[1];
				`PCS_ADDR_RX_UNDER_HI: rdata_next = hi_view[2];
				`PCS_ADDR_RX_UNDER_LO: rdata_next = lo_view[2];
				`PCS_ADDR_RX_INERR: rdata_next = lo_view[3];
				`PCS_ADDR_RX_OVERERR: rdata_next = lo_view[4];
				`PCS_ADDR_RX_FRAG: rdata_next = lo_view[5];
				`PCS_ADDR_RX_NOSFD: rdata_next = lo_view[6];
				`PCS_ADDR_TX_GOOD_HI: rdata_next = hi_view[7];
				`PCS_ADDR_TX_GOOD_LO: rdata_next = lo_view[7];
				`PCS_ADDR_TX_OVER_HI: rdata_next = hi_view[8];
				`PCS_ADDR_TX_OVER_LO: rdata_next = lo_view[8];
				`PCS_ADDR_TX_UNDER_HI: rdata_next = hi_view[9];
				`PCS_ADDR_TX_UNDER_LO: rdata_next = lo_view[9];
				`PCS_ADDR_TX_INERR: rdata_next = lo_view[10];
				`PCS_ADDR_TX_OVERERR: rdata_next = lo_view[11];
				`PCS_ADDR_TX_FRAG: rdata_next = lo_view[12];
				`PCS_ADDR_TX_NOSFD: rdata_next = lo_view[13];
				default: rdata_next = `PCS_RST_WORD;
			endcase
		end
	end

	// Sticky event status: a new event wins over the clearing read
	assign irq_stat_next = (rd_stat ? `PCS_RST_IRQ : irq_stat_reg) | ev_all;

	// Software-written control and mask registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			checker_enable_reg <= 1'b0;
			tx_checker_source_select_reg <= 1'b0;
			irq_mask_reg <= `PCS_RST_IRQ;
		end else begin
			if (wr_ctrl) begin
				checker_enable_reg <= reg_wdata[`PCS_BIT_CHK_EN];
			end
			if (wr_ctrl2) begin
				tx_checker_source_select_reg <= reg_wdata[`PCS_BIT_TX_SRC];
			end
			if (wr_mask) begin
				irq_mask_reg <= reg_wdata[NCNT-1:0];
			end
		end
	end

	// Status and read data registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_reg <= `PCS_RST_IRQ;
			rdata_reg <= `PCS_RST_WORD;
		end else begin
			irq_stat_reg <= irq_stat_next;
			rdata_reg <= rdata_next;
		end
	end

	// Outputs
	assign reg_rdata = rdata_reg;
	assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule

// File: design/pcs_consts.svh
`ifndef PCS_CONSTS_SVH
`define PCS_CONSTS_SVH

// Register offsets on the management port
`define PCS_ADDR_CTRL 16'h40A0
`define PCS_ADDR_RX_GOOD_HI 16'h40A3
`define PCS_ADDR_RX_GOOD_LO 16'h40A4
`define PCS_ADDR_RX_OVER_HI 16'h40A5
`define PCS_ADDR_RX_OVER_LO 16'h40A6
`define PCS_ADDR_RX_UNDER_HI 16'h40A7
`define PCS_ADDR_RX_UNDER_LO 16'h40A8
`define PCS_ADDR_RX_INERR 16'h40A9
`define PCS_ADDR_RX_OVERERR 16'h40AA
`define PCS_ADDR_RX_FRAG 16'h40AB
`define PCS_ADDR_RX_NOSFD 16'h40AC
`define PCS_ADDR_TX_GOOD_HI 16'h40AD
`define PCS_ADDR_TX_GOOD_LO 16'h40AE
`define PCS_ADDR_TX_OVER_HI 16'h40AF
`define PCS_ADDR_TX_OVER_LO 16'h40B0
`define PCS_ADDR_TX_UNDER_HI 16'h40B1
`define PCS_ADDR_TX_UNDER_LO 16'h40B2
`define PCS_ADDR_TX_INERR 16'h40B3
`define PCS_ADDR_TX_OVERERR 16'h40B4
`define PCS_ADDR_TX_FRAG 16'h40B5
`define PCS_ADDR_TX_NOSFD 16'h40B6
`define PCS_ADDR_CTRL2 16'h40B7
`define PCS_ADDR_IRQ_STAT 16'h40F0
`define PCS_ADDR_IRQ_MASK 16'h40F1

// Field positions
`define PCS_BIT_CHK_EN 15
`define PCS_BIT_TX_SRC 1

// Reset values
`define PCS_RST_WORD 16'h0000
`define PCS_RST_CNT 32'h0000_0000
`define PCS_RST_IRQ 14'h0000

// Event positions inside one checker's event vector
`define PCS_EV_GOOD 0
`define PCS_EV_OVER_GOOD 1
`define PCS_EV_UNDER_GOOD 2
`define PCS_EV_INRANGE_ERR 3
`define PCS_EV_OVER_ERR 4
`define PCS_EV_FRAG 5
`define PCS_EV_NOSFD 6

// Frame format constants
`define PCS_LEN_MIN 11'h040
`define PCS_LEN_MAX 11'h5EE
`define PCS_LEN_SAT 11'h7FF
`define PCS_NIB_PRE 4'h5
`define PCS_NIB_SFD 4'hD
`define PCS_CRC_INIT 32'hFFFF_FFFF
`define PCS_CRC_POLY 32'hEDB8_8320
`define PCS_CRC_RESIDUE 32'hDEBB_20E3

`endif

// File: design/pcs_pkg.sv
package pcs_pkg;
	typedef logic [15:0] pcs_word_t;
	typedef logic [3:0] pcs_nib_t;
	typedef logic [6:0] pcs_evt_t;
	typedef enum logic [1:0] {PCS_IDLE, PCS_PRE, PCS_BODY, PCS_SKIP} pcs_chk_state_t;
endpackage

// File: design/pcs_evt_if.sv
`timescale 1ns/1ps
// Frame classification pulses from one checker to the counter bank
interface pcs_evt_if;
	pcs_pkg::pcs_evt_t evt;
	modport src (output evt);
	modport dst (input evt);
endinterface

// File: design/pcs_frame_check.sv
`timescale 1ns/1ps
`include "pcs_consts.svh"
module pcs_frame_check (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Control
	input wire logic enable,
	// Nibble stream
	input wire logic nib_vld,
	input wire logic frame_dv,
	input wire pcs_pkg::pcs_nib_t nib,
	// Classification pulses
	pcs_evt_if.src ev
);
	import pcs_pkg::*;

	pcs_chk_state_t state_reg, state_next;
	logic [31:0] crc_reg;
	logic [10:0] len_reg;
	logic half_reg;
	pcs_evt_t evt_reg, evt_next;

	// Nibble-wide reflected CRC-32 step, low data bit first
	function automatic logic [31:0] crc_step(input logic [31:0] c, input pcs_nib_t d);
		logic [31:0] r;
		r = c;
		for (int i = 0; i < 4; i++) begin
			r = (r[0] ^ d[i]) ? ((r >> 1) ^ `PCS_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	wire crc_ok = (crc_reg == `PCS_CRC_RESIDUE);
	wire is_short = (len_reg < `PCS_LEN_MIN);
	wire is_long = (len_reg > `PCS_LEN_MAX);
	wire frame_end = nib_vld && !frame_dv;

	// Walk preamble, delimiter and body; classify at the end of carrier
	always_comb begin
		state_next = state_reg;
		evt_next = '0;
		case (state_reg)
			PCS_IDLE: begin
				if (enable && nib_vld && frame_dv) begin
					state_next = (nib == `PCS_NIB_SFD) ? PCS_BODY :
						(nib == `PCS_NIB_PRE) ? PCS_PRE : PCS_SKIP;
				end
			end
			PCS_PRE: begin
				if (frame_end) begin
					evt_next[`PCS_EV_NOSFD] = 1'b1;
					state_next = PCS_IDLE;
				end else if (nib_vld && nib == `PCS_NIB_SFD) begin
					state_next = PCS_BODY;
				end else if (nib_vld && nib != `PCS_NIB_PRE) begin
					state_next = PCS_SKIP;
				end
			end
			PCS_SKIP: begin
				if (frame_end) begin
					evt_next[`PCS_EV_NOSFD] = 1'b1;
					state_next = PCS_IDLE;
				end
			end
			PCS_BODY: begin
				if (frame_end) begin
					state_next = PCS_IDLE;
					evt_next[`PCS_EV_FRAG] = is_short;
					evt_next[`PCS_EV_UNDER_GOOD] = is_short && crc_ok;
					evt_next[`PCS_EV_GOOD] = !is_short && !is_long && crc_ok;
					evt_next[`PCS_EV_INRANGE_ERR] = !is_short && !is_long && !crc_ok;
					evt_next[`PCS_EV_OVER_GOOD] = is_long && crc_ok;
					evt_next[`PCS_EV_OVER_ERR] = is_long && !crc_ok;
				end
			end
			default: state_next = PCS_IDLE;
		endcase
		if (!enable) begin
			state_next = PCS_IDLE;
			evt_next = '0;
		end
	end

	// State, CRC and length registers
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= PCS_IDLE;
			crc_reg <= `PCS_CRC_INIT;
			len_reg <= '0;
			half_reg <= 1'b0;
			evt_reg <= '0;
		end else begin
			state_reg <= state_next;
			evt_reg <= evt_next;
			if (state_reg != PCS_BODY) begin
				crc_reg <= `PCS_CRC_INIT;
				len_reg <= '0;
				half_reg <= 1'b0;
			end else if (nib_vld && frame_dv) begin
				crc_reg <= crc_step(crc_reg, nib);
				half_reg <= !half_reg;
				if (half_reg && len_reg != `PCS_LEN_SAT) begin
					len_reg <= len_reg + 11'h001;
				end
			end
		end
	end

	assign ev.evt = evt_reg;
endmodule

// File: sim/pcs_stat_counters_props.sv
`timescale 1ns/1ps
module pcs_stat_counters_props (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register port
	input wire pcs_pkg::pcs_word_t reg_addr,
	input wire pcs_pkg::pcs_word_t reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire pcs_pkg::pcs_word_t reg_rdata,
	// Nibble streams
	input wire logic rx_nib_vld,
	input wire logic rx_dv,
	input wire pcs_pkg::pcs_nib_t rx_nib,
	input wire logic mac_tx_nib_vld,
	input wire logic mac_tx_en,
	input wire pcs_pkg::pcs_nib_t mac_tx_nib,
	input wire logic gen_tx_nib_vld,
	input wire logic gen_tx_en,
	input wire pcs_pkg::pcs_nib_t gen_tx_nib,
	// Interrupt
	input wire logic irq
);
	import pcs_pkg::*;
	logic en_q;
	logic seen_q;
	logic src_q;
	logic [13:0] mask_q;
	logic [2:0] quiet_q;
	// Address decode of the watched accesses
	wire logic any_vld = rx_nib_vld | mac_tx_nib_vld | gen_tx_nib_vld;
	wire logic rd_cnt = reg_rd && reg_addr >= 16'h40A3 && reg_addr <= 16'h40B6;
	wire logic wr_ctrl = reg_wr && reg_addr == 16'h40A0;
	wire logic wr_src = reg_wr && reg_addr == 16'h40B7;
	wire logic wr_mask = reg_wr && reg_addr == 16'h40F1;
	// Copies of the settings and cycles since the last nibble
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= 1'b0;
			seen_q <= 1'b0;
			src_q <= 1'b0;
			mask_q <= 14'h0000;
			quiet_q <= 3'h0;
		end else begin
			en_q <= wr_ctrl ? reg_wdata[15] : en_q;
			seen_q <= seen_q | (wr_ctrl & reg_wdata[15]);
			src_q <= wr_src ? reg_wdata[1] : src_q;
			mask_q <= wr_mask ? reg_wdata[13:0] : mask_q;
			quiet_q <= any_vld ? 3'h0 : (quiet_q == 3'h7 ? quiet_q : quiet_q + 3'h1);
		end
	end
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
		else $error("read data not zero outside an answer");
	AST_REREAD_CLEARED: assert property (rd_cnt && $past(rd_cnt) && $stable(reg_addr)
		|=> reg_rdata <= 16'h0001) else $error("counter not cleared by read");
	AST_NO_COUNT_DISABLED: assert property (rd_cnt && !seen_q |=> reg_rdata == 16'h0000)
		else $error("count before checker enable");
	AST_CTRL_READBACK: assert property (reg_rd && reg_addr == 16'h40A0
		|=> reg_rdata == {en_q, 15'h0000}) else $error("control readback");
	AST_SRC_READBACK: assert property (reg_rd && reg_addr == 16'h40B7
		|=> reg_rdata == {14'h0000, src_q, 1'b0}) else $error("source readback");
	AST_IRQ_MASKED: assert property (mask_q == 14'h0000 |-> !irq)
		else $error("interrupt with all masked");
	AST_IRQ_CLEARED: assert property (reg_rd && reg_addr == 16'h40F0 && quiet_q >= 3'h3
		|=> !irq) else $error("interrupt kept after status read");
	AST_IRQ_CAUSE: assert property ($rose(irq)
		|-> $past(reg_wr) || $past(en_q) || $past(en_q, 2) || $past(en_q, 3))
		else $error("interrupt without enable");
endmodule
bind pcs_stat_counters pcs_stat_counters_props i_props (.core_clk, .rst_n, .reg_addr,
	.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_nib_vld, .rx_dv, .rx_nib, .mac_tx_nib_vld,
	.mac_tx_en, .mac_tx_nib, .gen_tx_nib_vld, .gen_tx_en, .gen_tx_nib, .irq);

// File: sim/pcs_nib_src.sv
`timescale 1ns/1ps
`include "pcs_consts.svh"
module pcs_nib_src (
	// Clock
	input wire logic core_clk,
	// Nibble stream
	output logic nib_vld,
	output logic dv,
	output pcs_pkg::pcs_nib_t nib
);
	import pcs_pkg::*;
	logic [7:0] frm [0:2047];
	// Idle stream
	initial begin
		nib_vld = 1'b0;
		dv = 1'b0;
		nib = 4'h0;
	end
	// One nibble, then idle cycles with the data line held inverted
	task automatic put(input logic v, input pcs_nib_t n, input int gap);
		@(posedge core_clk);
		nib_vld <= 1'b1;
		dv <= v;
		nib <= n;
		repeat (gap) begin
			@(posedge core_clk);
			nib_vld <= 1'b0;
			nib <= ~n;
		end
	endtask
	// Frame of len bytes, last four the FCS, broken on request
	task automatic send(input int len, input bit good, input bit sfd, input int gap);
		logic [31:0] crc;
		crc = `PCS_CRC_INIT;
		for (int i = 0; i < len; i++) begin
			if (i < len - 4) begin
				frm[i] = i[7:0] ^ 8'hA5;
				crc = crc ^ {24'h000000, frm[i]};
				repeat (8) crc = crc[0] ? (crc >> 1) ^ `PCS_CRC_POLY : crc >> 1;
			end else begin
				frm[i] = ~crc[8 * (i - len + 4) +: 8];
			end
		end
		if (!good) frm[len - 1] = frm[len - 1] ^ 8'h01;
		repeat (15) put(1'b1, `PCS_NIB_PRE, gap);
		put(1'b1, sfd ? `PCS_NIB_SFD : 4'h7, gap);
		for (int i = 0; i < len; i++) begin
			put(1'b1, frm[i][3:0], gap);
			put(1'b1, frm[i][7:4], gap);
		end
		put(1'b0, 4'h0, gap);
		@(posedge core_clk);
		nib_vld <= 1'b0;
		dv <= 1'b0;
	endtask
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
	import pcs_pkg::*;
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	pcs_word_t reg_addr = 16'h0000;
	pcs_word_t reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	pcs_word_t reg_rdata;
	logic irq;
	wire [2:0] vld;
	wire [2:0] dv;
	wire [3:0] nib [3];
	int errors = 0;
	int n_compared = 0;
	int exp_cnt [14];
	logic [15:0] off [7] = '{16'h3, 16'h5, 16'h7, 16'h9, 16'hA, 16'hB, 16'hC};
	// Clock
	always #4 core_clk = ~core_clk;
	// Frame sources: wire side, MAC and generator
	pcs_nib_src i_rx (.core_clk, .nib_vld(vld[0]), .dv(dv[0]), .nib(nib[0]));
	pcs_nib_src i_mac (.core_clk, .nib_vld(vld[1]), .dv(dv[1]), .nib(nib[1]));
	pcs_nib_src i_gen (.core_clk, .nib_vld(vld[2]), .dv(dv[2]), .nib(nib[2]));
	pcs_stat_counters i_dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .rx_nib_vld(vld[0]), .rx_dv(dv[0]), .rx_nib(nib[0]),
		.mac_tx_nib_vld(vld[1]), .mac_tx_en(dv[1]), .mac_tx_nib(nib[1]),
		.gen_tx_nib_vld(vld[2]), .gen_tx_en(dv[2]), .gen_tx_nib(nib[2]), .irq);
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// Two reads back to back, first answer in the upper half
	task automatic rd2(input logic [15:0] a, input logic [15:0] b, output logic [31:0] d);
		@(posedge core_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_addr <= b;
		#1 d[31:16] = reg_rdata;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d[15:0] = reg_rdata;
	endtask
	// Send one frame and book where it should land
	task automatic run(input int s, input int len, input bit ok, input bit sfd, input int gap,
		input bit counts);
		int k;
		if (!sfd) k = 6;
		else if (len < 64) k = ok ? 2 : 5;
		else if (len <= 1518) k = ok ? 0 : 3;
		else k = ok ? 1 : 4;
		if (s == 0) i_rx.send(len, ok, sfd, gap);
		else if (s == 1) i_mac.send(len, ok, sfd, gap);
		else i_gen.send(len, ok, sfd, gap);
		repeat (3) @(posedge core_clk);
		k = k + (s == 0 ? 0 : 7);
		if (counts) exp_cnt[k]++;
		if (counts && k % 7 == 2) exp_cnt[k + 3]++;
	endtask
	task automatic check_all();
		logic [31:0] v;
		logic [15:0] a;
		for (int i = 0; i < 14; i++) begin
			a = 16'h40A0 + off[i % 7] + (i >= 7 ? 16'h000A : 16'h0000);
			v = 32'h0;
			if (i % 7 < 3) rd2(a, a + 16'h0001, v);
			else rd(a, v[15:0]);
			check(v, exp_cnt[i]);
			exp_cnt[i] = 0;
		end
	endtask
	task automatic burst(input int s);
		int len [9] = '{64, 1518, 1519, 63, 64, 1518, 1519, 20, 64};
		bit [8:0] ok = 9'b100001111;
		bit [8:0] sf = 9'b011111111;
		for (int i = 0; i < 9; i++) run(s, len[i], ok[i], sf[i], s, 1'b1);
	endtask
	task automatic t_reset();
		logic [15:0] v;
		for (int a = 16'h40A0; a <= 16'h40B7; a++) begin
			rd(a[15:0], v);
			check(v, 16'h0000);
		end
		wr(16'h40A9, 16'hFFFF);
		rd(16'h40A9, v);
		check(v, 16'h0000);
		rd(16'h1234, v);
		check(v, 16'h0000);
		run(0, 64, 1'b1, 1'b1, 0, 1'b0);
		check_all();
	endtask
	task automatic t_rx();
		logic [31:0] v;
		wr(16'h40A0, 16'h8000);
		rd(16'h40A0, v[15:0]);
		check(v[15:0], 16'h8000);
		burst(0);
		rd2(16'h40A9, 16'h40A9, v);
		check(v, 32'h0002_0000);
		exp_cnt[3] = 0;
		// Low half read alone clears only the low half
		rd(16'h40A4, v[15:0]);
		check(v[15:0], 16'h0002);
		exp_cnt[0] = 0;
		check_all();
	endtask
	task automatic t_tx();
		logic [15:0] v;
		burst(1);
		run(2, 64, 1'b1, 1'b1, 0, 1'b0);
		wr(16'h40B7, 16'h0002);
		rd(16'h40B7, v);
		check(v, 16'h0002);
		run(1, 64, 1'b1, 1'b1, 0, 1'b0);
		run(2, 63, 1'b0, 1'b1, 0, 1'b1);
		check_all();
	endtask
	task automatic t_irq();
		logic [15:0] v;
		// Every event class fired earlier, so all status bits are pending; the read clears them
		rd(16'h40F0, v);
		check(v, 16'h3FFF);
		wr(16'h40F1, 16'h0001);
		run(0, 64, 1'b1, 1'b0, 0, 1'b1);
		check(irq, 1'b0);
		rd(16'h40F0, v);
		check(v, 16'h0040);
		run(0, 64, 1'b1, 1'b1, 0, 1'b1);
		check(irq, 1'b1);
		rd(16'h40F0, v);
		check(v, 16'h0001);
		check(irq, 1'b0);
		wr(16'h40A0, 16'h0000);
		run(0, 64, 1'b1, 1'b1, 0, 1'b0);
		check_all();
	endtask
	task automatic final_report();
		$display("compared %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (12) @(posedge core_clk);
		rst_n <= 1'b1;
		t_reset();
		t_rx();
		t_tx();
		t_irq();
		final_report();
	end
	// Watchdog, well past the expected run length
	initial begin
		repeat (90000) @(posedge core_clk);
		errors++;
		final_report();
	end
endmodule
